// File: logic/dram_bank_tracker.sv
// device end: samples the link and keeps a state record per bank
`timescale 1ns/10ps
`default_nettype none
module dram_bank_tracker
  import lpddr_bank_pkg::*;
(
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  // link from the controller
  lpddr_link_if.dev   link,
  // bank records and command results
  output var bank_state_t state_out [BANKS],
  output logic        taken_out,
  output logic        illegal_out
);

  // synchroniser stages and edge history
  logic             ck_s1_q, ck_s2_q, ck_s3_q;
  logic             cke_s1_q, cke_s2_q, ap_s1_q, ap_s2_q;
  cmd_t             cmd_s1_q, cmd_s2_q;
  logic [BA_W-1:0]  ba_s1_q, ba_s2_q;

  // command gating
  logic             cke_prev_q, cke_prev_d;
  logic [TMR_W-1:0] xp_q, xp_d;
  logic             edge_seen, cmd_ok, legal, go;
  logic             taken_q, taken_d, illegal_q, illegal_d;

  // activate spacing
  logic [TMR_W-1:0] rrd_q, rrd_d;
  logic [TMR_W-1:0] faw_q [FAW_SLOTS];
  logic [TMR_W-1:0] faw_d [FAW_SLOTS];
  logic             faw_ok, faw_put;

  // bank records
  bank_state_t      st_q [BANKS];
  bank_state_t      st_d [BANKS];
  logic [TMR_W-1:0] tmr_q [BANKS];
  logic [TMR_W-1:0] tmr_d [BANKS];
  bank_state_t      tgt;
  logic             any_rd, any_wr, any_mr, all_idle, all_pre_ok;

  assign taken_out = taken_q;
  assign illegal_out = illegal_q;

  // two flops on every link input, a third only for the clock edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      cke_s1_q <= 1'b0;
      cke_s2_q <= 1'b0;
      ap_s1_q <= 1'b0;
      ap_s2_q <= 1'b0;
      cmd_s1_q <= CMD_NOP;
      cmd_s2_q <= CMD_NOP;
      ba_s1_q <= '0;
      ba_s2_q <= '0;
    end else begin
      ck_s1_q <= link.ck;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      cke_s1_q <= link.cke;
      cke_s2_q <= cke_s1_q;
      ap_s1_q <= link.ap;
      ap_s2_q <= ap_s1_q;
      cmd_s1_q <= link.cmd;
      cmd_s2_q <= cmd_s1_q;
      ba_s1_q <= link.ba;
      ba_s2_q <= ba_s1_q;
    end
  end

  // summaries over all bank records
  always_comb begin
    any_rd = 1'b0;
    any_wr = 1'b0;
    any_mr = 1'b0;
    all_idle = 1'b1;
    all_pre_ok = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      any_rd = any_rd | (st_q[i] inside {ST_READING, ST_READ_AP});
      any_wr = any_wr | (st_q[i] inside {ST_WRITING, ST_WRITE_AP});
      any_mr = any_mr | (st_q[i] inside {ST_MRR_IDLE, ST_MRR_ACTIVE,
                                         ST_MRW_IDLE});
      all_idle = all_idle & (st_q[i] == ST_IDLE);
      all_pre_ok = all_pre_ok & (st_q[i] inside {ST_IDLE, ST_ACTIVE,
                   ST_READING, ST_WRITING, ST_PRECHARGING});
    end
    faw_ok = 1'b0;
    for (int i = 0; i < FAW_SLOTS; i++) begin
      faw_ok = faw_ok | (faw_q[i] == '0);
    end
  end

  // sampling edge, cke gating and legality of the command
  always_comb begin
    edge_seen = ck_s2_q & ~ck_s3_q;
    cmd_ok = edge_seen & cke_prev_q & cke_s2_q & (xp_q == '0);
    cke_prev_d = edge_seen ? cke_s2_q : cke_prev_q;
    xp_d = ~cke_s2_q ? XP_CYC : (xp_q == '0 ? xp_q : xp_q - TMR_W'(1));
    tgt = st_q[ba_s2_q];
    legal = 1'b0; // anything not listed is refused
    unique case (cmd_s2_q)
      CMD_NOP: legal = 1'b1;
      CMD_ACT: legal = (tgt == ST_IDLE) & ~any_mr & (rrd_q == '0)
                       & faw_ok;
      CMD_RD: legal = (tgt inside {ST_ACTIVE, ST_READING})
                      & ~any_wr & ~any_mr;
      CMD_WR, CMD_MWR: legal = (tgt inside {ST_ACTIVE, ST_WRITING})
                               & ~any_rd & ~any_mr;
      CMD_PRE: legal = (tgt inside {ST_IDLE, ST_ACTIVE, ST_READING,
                        ST_WRITING, ST_PRECHARGING}) & ~any_mr;
      CMD_PREA: legal = all_pre_ok & ~any_mr;
      CMD_MRR: legal = (tgt inside {ST_IDLE, ST_ACTIVATING, ST_ACTIVE,
                        ST_PRECHARGING}) & ~any_rd & ~any_wr
                       & ~any_mr;
      CMD_MRW, CMD_REF: legal = all_idle;
      default: legal = 1'b0;
    endcase
    go = cmd_ok & legal;
    taken_d = go;
    illegal_d = cmd_ok & ~legal;
  end

  // row-to-row and four-activate window counters
  always_comb begin
    rrd_d = (rrd_q == '0) ? rrd_q : rrd_q - TMR_W'(1);
    if (go && cmd_s2_q == CMD_ACT) begin
      rrd_d = RRD_CYC;
    end
    faw_put = 1'b0;
    for (int i = 0; i < FAW_SLOTS; i++) begin
      faw_d[i] = (faw_q[i] == '0) ? faw_q[i] : faw_q[i] - TMR_W'(1);
      if (go && cmd_s2_q == CMD_ACT && !faw_put && faw_q[i] == '0) begin
        faw_d[i] = FAW_CYC;
        faw_put = 1'b1;
      end
    end
  end

  // gating, spacing and result registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cke_prev_q <= 1'b0;
      xp_q <= '0;
      taken_q <= 1'b0;
      illegal_q <= 1'b0;
      rrd_q <= '0;
      for (int i = 0; i < FAW_SLOTS; i++) begin
        faw_q[i] <= '0;
      end
    end else begin
      cke_prev_q <= cke_prev_d;
      xp_q <= xp_d;
      taken_q <= taken_d;
      illegal_q <= illegal_d;
      rrd_q <= rrd_d;
      faw_q <= faw_d;
    end
  end

  // one state record and timer per bank
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    logic hit;

    // command to this bank first, otherwise timed settling
    always_comb begin
      hit = go & ((ba_s2_q == BA_W'(b)) |
                  (cmd_s2_q inside {CMD_PREA, CMD_MRW}));
      st_d[b] = st_q[b];
      tmr_d[b] = (tmr_q[b] == '0) ? tmr_q[b] : tmr_q[b] - TMR_W'(1);
      if (hit) begin
        unique case (cmd_s2_q)
          CMD_ACT: begin
            st_d[b] = ST_ACTIVATING;
            tmr_d[b] = RCD_CYC;
          end
          CMD_RD: begin
            st_d[b] = ap_s2_q ? ST_READ_AP : ST_READING;
            tmr_d[b] = BURST_CYC;
          end
          CMD_WR, CMD_MWR: begin
            st_d[b] = ap_s2_q ? ST_WRITE_AP : ST_WRITING;
            tmr_d[b] = BURST_CYC;
          end
          CMD_PRE, CMD_PREA: begin
            st_d[b] = ST_PRECHARGING;
            tmr_d[b] = RP_CYC;
          end
          CMD_MRR: begin
            // activating settles to active, precharging to idle
            st_d[b] = (st_q[b] inside {ST_ACTIVATING, ST_ACTIVE}) ?
                      ST_MRR_ACTIVE : ST_MRR_IDLE;
            tmr_d[b] = MRR_CYC;
          end
          CMD_MRW: begin
            st_d[b] = ST_MRW_IDLE;
            tmr_d[b] = MRW_CYC;
          end
          default: st_d[b] = st_q[b];
        endcase
      end else if (tmr_q[b] == '0) begin
        unique case (st_q[b])
          ST_ACTIVATING, ST_READING, ST_WRITING:
            st_d[b] = ST_ACTIVE;
          ST_MRR_ACTIVE: st_d[b] = ST_ACTIVE;
          ST_READ_AP, ST_WRITE_AP: begin
            st_d[b] = ST_PRECHARGING;
            tmr_d[b] = RP_CYC;
          end
          ST_PRECHARGING: st_d[b] = ST_IDLE;
          ST_MRR_IDLE: st_d[b] = ST_IDLE;
          ST_MRW_IDLE: st_d[b] = ST_IDLE;
          default: st_d[b] = st_q[b];
        endcase
      end
    end

    // record registers
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        st_q[b] <= ST_IDLE;
        tmr_q[b] <= '0;
      end else begin
        st_q[b] <= st_d[b];
        tmr_q[b] <= tmr_d[b];
      end
    end

    assign state_out[b] = st_q[b];
  end

endmodule
`default_nettype wire

// File: logic/lpddr_bank_pkg.sv
// shared constants and types for the bank command tracker and issuer
`default_nettype none
package lpddr_bank_pkg;

  // bank organisation
  localparam int BANKS = 8;
  localparam int BA_W  = 3;
  localparam int TMR_W = 8;
  localparam int FAW_SLOTS = 4;

  // local clock and link clock divider
  localparam int CLK_NS = 40;
  localparam int CK_DIV = 8;
  localparam int DIV_W  = 3;

  // least timings in ns, rounded up to clk cycles
  localparam int T_RCD_NS = 18;
  localparam int T_RP_NS  = 18;
  localparam int T_RRD_NS = 10;
  localparam int T_FAW_NS = 40;
  localparam int T_XP_NS  = 8;

  // timings in link clock periods
  localparam int BL_TCK    = 8;
  localparam int T_MRR_TCK = 8;
  localparam int T_MRW_TCK = 10;

  localparam logic [TMR_W-1:0] RCD_CYC =
    TMR_W'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] RP_CYC =
    TMR_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] RRD_CYC =
    TMR_W'((T_RRD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] FAW_CYC =
    TMR_W'((T_FAW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] XP_CYC =
    TMR_W'((T_XP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] BURST_CYC = TMR_W'(BL_TCK * CK_DIV);
  localparam logic [TMR_W-1:0] MRR_CYC   = TMR_W'(T_MRR_TCK * CK_DIV);
  localparam logic [TMR_W-1:0] MRW_CYC   = TMR_W'(T_MRW_TCK * CK_DIV);

  // divider phases
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(CK_DIV / 2);

  // commands on the link
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_MWR,
    CMD_PRE, CMD_PREA, CMD_MRR, CMD_MRW, CMD_REF
  } cmd_t;

  // per-bank state record
  typedef enum logic [3:0] {
    ST_IDLE, ST_ACTIVATING, ST_ACTIVE, ST_READING, ST_WRITING,
    ST_READ_AP, ST_WRITE_AP, ST_PRECHARGING,
    ST_MRR_IDLE, ST_MRR_ACTIVE, ST_MRW_IDLE
  } bank_state_t;

endpackage
`default_nettype wire

// File: logic/lpddr_link_if.sv
// command link between the issuing controller and the bank tracker
`timescale 1ns/10ps
`default_nettype none
interface lpddr_link_if;
  import lpddr_bank_pkg::*;
  logic             ck;
  logic             cke;
  cmd_t             cmd;
  logic [BA_W-1:0]  ba;
  logic             ap;
  modport ctrl (output ck, cke, cmd, ba, ap);
  modport dev  (input ck, cke, cmd, ba, ap);
endinterface
`default_nettype wire

// File: logic/dram_cmd_issuer.sv
// controller end: divides the link clock and issues only legal commands
`timescale 1ns/10ps
`default_nettype none
module dram_cmd_issuer
  import lpddr_bank_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // link to the device
  lpddr_link_if.ctrl            link,
  // user side
  input  wire logic             cke_en_in,
  input  wire logic             req_valid_in,
  input  wire cmd_t             req_cmd_in,
  input  wire logic [BA_W-1:0]  req_bank_in,
  input  wire logic             req_ap_in,
  output logic                  req_ready_out,
  output logic                  req_reject_out
);

  logic [DIV_W-1:0] div_q, div_d;
  logic             ck_q, ck_d, cke_q, cke_d, cke_prev_q, cke_prev_d;
  logic             ap_q, ap_d;
  cmd_t             cmd_q, cmd_d;
  logic [BA_W-1:0]  ba_q, ba_d;
  logic [TMR_W-1:0] xp_q, xp_d, rd_q, rd_d, wr_q, wr_d, mr_q, mr_d;
  logic [TMR_W-1:0] rrd_q, rrd_d;
  logic [TMR_W-1:0] wait_q [BANKS];
  logic [TMR_W-1:0] wait_d [BANKS];
  logic [TMR_W-1:0] faw_q [FAW_SLOTS];
  logic [TMR_W-1:0] faw_d [FAW_SLOTS];
  logic [BANKS-1:0] open_q, open_d;
  logic tick, cke_ok, struct_ok, time_ok, take, issue;
  logic all_closed, all_free, faw_ok, faw_put;

  assign link.ck  = ck_q;
  assign link.cke = cke_q;
  assign link.cmd = cmd_q;
  assign link.ba  = ba_q;
  assign link.ap  = ap_q;
  assign req_ready_out  = take;
  assign req_reject_out = take & ~struct_ok;

  // request checking and all next values
  always_comb begin
    tick = (div_q == DIV_LAST);
    cke_ok = cke_q & cke_prev_q & (xp_q == '0) & cke_en_in;
    all_closed = ~|open_q;
    all_free = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      all_free = all_free & (wait_q[i] == '0);
    end
    faw_ok = 1'b0;
    for (int i = 0; i < FAW_SLOTS; i++) begin
      faw_ok = faw_ok | (faw_q[i] == '0);
    end
    // structural check refuses combinations never allowed
    struct_ok = 1'b1;
    time_ok = (mr_q == '0); // only nop while mode register busy
    unique case (req_cmd_in)
      CMD_NOP: time_ok = 1'b1;
      CMD_ACT: begin
        struct_ok = ~open_q[req_bank_in];
        time_ok = time_ok & (wait_q[req_bank_in] == '0)
                  & (rrd_q == '0) & faw_ok;
      end
      CMD_RD: begin
        struct_ok = open_q[req_bank_in];
        time_ok = time_ok & (wait_q[req_bank_in] == '0)
                  & (wr_q == '0);
      end
      CMD_WR, CMD_MWR: begin
        struct_ok = open_q[req_bank_in];
        time_ok = time_ok & (wait_q[req_bank_in] == '0)
                  & (rd_q == '0);
      end
      CMD_PRE: time_ok = time_ok & (wait_q[req_bank_in] == '0);
      CMD_PREA: time_ok = time_ok & all_free;
      CMD_MRR: time_ok = time_ok & (rd_q == '0) & (wr_q == '0);
      CMD_MRW, CMD_REF: begin
        struct_ok = all_closed;
        time_ok = time_ok & all_free & (rd_q == '0) & (wr_q == '0);
      end
      default: struct_ok = 1'b0;
    endcase
    take = tick & req_valid_in & cke_ok & (time_ok | ~struct_ok);
    issue = take & struct_ok;
    // divider, pins and cke exit
    div_d = tick ? '0 : div_q + DIV_W'(1);
    ck_d = (div_d >= DIV_HALF);
    cmd_d = cmd_q;
    ba_d = ba_q;
    ap_d = ap_q;
    cke_d = cke_q;
    cke_prev_d = cke_prev_q;
    if (tick) begin
      cmd_d = issue ? req_cmd_in : CMD_NOP;
      ba_d = req_bank_in;
      ap_d = req_ap_in;
      cke_d = cke_en_in;
      cke_prev_d = cke_q;
    end
    xp_d = ~cke_q ? XP_CYC + TMR_W'(1)
                  : (xp_q == '0 ? xp_q : xp_q - TMR_W'(1));
    rd_d = (rd_q == '0) ? rd_q : rd_q - TMR_W'(1);
    wr_d = (wr_q == '0) ? wr_q : wr_q - TMR_W'(1);
    mr_d = (mr_q == '0) ? mr_q : mr_q - TMR_W'(1);
    rrd_d = (rrd_q == '0) ? rrd_q : rrd_q - TMR_W'(1);
    open_d = open_q;
    for (int i = 0; i < BANKS; i++) begin
      wait_d[i] = (wait_q[i] == '0) ? wait_q[i] : wait_q[i] - TMR_W'(1);
    end
    faw_put = 1'b0;
    for (int i = 0; i < FAW_SLOTS; i++) begin
      faw_d[i] = (faw_q[i] == '0) ? faw_q[i] : faw_q[i] - TMR_W'(1);
      if (issue && req_cmd_in == CMD_ACT && !faw_put && faw_q[i] == '0) begin
        faw_d[i] = FAW_CYC + TMR_W'(1);
        faw_put = 1'b1;
      end
    end
    // bookkeeping of the issued command
    if (issue) begin
      unique case (req_cmd_in)
        CMD_ACT: begin
          open_d[req_bank_in] = 1'b1;
          wait_d[req_bank_in] = RCD_CYC + TMR_W'(1);
          rrd_d = RRD_CYC + TMR_W'(1);
        end
        CMD_RD, CMD_WR, CMD_MWR: begin
          if (req_cmd_in == CMD_RD) begin
            rd_d = BURST_CYC + TMR_W'(1);
          end else begin
            wr_d = BURST_CYC + TMR_W'(1);
          end
          wait_d[req_bank_in] = BURST_CYC + TMR_W'(1);
          if (req_ap_in) begin
            open_d[req_bank_in] = 1'b0;
            wait_d[req_bank_in] = BURST_CYC + RP_CYC + TMR_W'(2);
          end
        end
        CMD_PRE: begin
          open_d[req_bank_in] = 1'b0;
          wait_d[req_bank_in] = RP_CYC + TMR_W'(1);
        end
        CMD_PREA: begin
          open_d = '0;
          for (int i = 0; i < BANKS; i++) begin
            wait_d[i] = RP_CYC + TMR_W'(1);
          end
        end
        CMD_MRR: mr_d = MRR_CYC + TMR_W'(1);
        CMD_MRW: mr_d = MRW_CYC + TMR_W'(1);
        default: ;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_q <= '0;
      ck_q <= 1'b0;
      cke_q <= 1'b0;
      cke_prev_q <= 1'b0;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      ap_q <= 1'b0;
      xp_q <= '0;
      rd_q <= '0;
      wr_q <= '0;
      mr_q <= '0;
      rrd_q <= '0;
      open_q <= '0;
      for (int i = 0; i < BANKS; i++) begin
        wait_q[i] <= '0;
      end
      for (int i = 0; i < FAW_SLOTS; i++) begin
        faw_q[i] <= '0;
      end
    end else begin
      div_q <= div_d;
      ck_q <= ck_d;
      cke_q <= cke_d;
      cke_prev_q <= cke_prev_d;
      cmd_q <= cmd_d;
      ba_q <= ba_d;
      ap_q <= ap_d;
      xp_q <= xp_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      mr_q <= mr_d;
      rrd_q <= rrd_d;
      open_q <= open_d;
      wait_q <= wait_d;
      faw_q <= faw_d;
    end
  end

endmodule
`default_nettype wire

// File: verification/dram_link_properties.sv
// checker of link timing and per-bank state sequences
`timescale 1ns/10ps
`default_nettype none
module dram_link_checker
  import lpddr_bank_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // link signals
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire cmd_t        cmd,
  // tracker results
  input  var bank_state_t  state_out [BANKS],
  input  wire logic        taken_out,
  input  wire logic        illegal_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // link clock shape, command and enable launched at the falling edge
  a_ck_high_four: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
    else $error("link clock high phase not four cycles");
  a_cmd_at_fall: assert property ($changed(cmd) |-> $fell(ck))
    else $error("command changed away from clock fall");
  a_cke_at_fall: assert property ($changed(cke) |-> $fell(ck))
    else $error("clock enable changed away from clock fall");
  // results only for edges where enable was high twice
  a_pulse_after_edge: assert property (
    (taken_out || illegal_out) |-> ($past(ck, 3) || $past(ck, 4)))
    else $error("result pulse not tied to a link clock edge");
  a_cke_twice_high: assert property (
    (taken_out || illegal_out) |-> ($past(cke, 4) && $past(cke, 11)))
    else $error("command counted without enable high twice");
  a_never_illegal: assert property (!illegal_out)
    else $error("issuer sent a command the tracker refused");

  // state durations of each bank
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    a_rcd_to_active: assert property (
      ($changed(state_out[b]) && state_out[b] == ST_ACTIVATING) |=>
      state_out[b] == ST_ACTIVATING ##1 state_out[b] == ST_ACTIVE)
      else $error("activating did not settle to active in time");
    a_rp_to_idle: assert property (
      ($changed(state_out[b]) && state_out[b] == ST_PRECHARGING) |=>
      state_out[b] == ST_PRECHARGING ##1 state_out[b] == ST_IDLE)
      else $error("precharging did not settle to idle in time");
    a_burst_length: assert property (
      ($changed(state_out[b]) && state_out[b] == ST_READING) |->
      ##64 state_out[b] == ST_READING ##1 state_out[b] == ST_ACTIVE)
      else $error("read burst length wrong");
    a_mrr_length: assert property (
      ($changed(state_out[b]) && state_out[b] == ST_MRR_ACTIVE) |->
      ##64 state_out[b] == ST_MRR_ACTIVE ##1 state_out[b] == ST_ACTIVE)
      else $error("mode read state length wrong");
    a_mrw_length: assert property (
      ($changed(state_out[b]) && state_out[b] == ST_MRW_IDLE) |->
      ##80 state_out[b] == ST_MRW_IDLE ##1 state_out[b] == ST_IDLE)
      else $error("mode write state length wrong");
  end

  // main scenarios reached
  c_read_ap: cover property (state_out[1] == ST_READ_AP);
  c_write_ap: cover property (state_out[4] == ST_WRITE_AP);
  c_mrr_idle: cover property (state_out[6] == ST_MRR_IDLE);
  c_mrw: cover property (state_out[0] == ST_MRW_IDLE);
endmodule
`default_nettype wire

// File: verification/tb_dram_inter_bank_command_rules.sv
// testbench: issuer and tracker face to face, plus a rule-breaking link
`timescale 1ns/10ps
`default_nettype none
module tb_dram_inter_bank_command_rules;
  import lpddr_bank_pkg::*;

  // clock, reset and issuer user side
  logic            clk_in;
  logic            rst_in;
  logic            cke_en_in;
  logic            req_valid_in;
  cmd_t            req_cmd_in;
  logic [BA_W-1:0] req_bank_in;
  logic            req_ap_in;
  logic            req_ready_out;
  logic            req_reject_out;
  // tracker results on both links
  bank_state_t     st_a [BANKS];
  bank_state_t     st_b [BANKS];
  logic            taken_a;
  logic            ill_a;
  logic            taken_b;
  logic            ill_b;
  int              num_errors;
  int              cmp_count;

  lpddr_link_if lk ();
  lpddr_link_if lk2 ();

  dram_cmd_issuer i_dram_cmd_issuer (
    .clk_in(clk_in), .rst_in(rst_in), .link(lk), .cke_en_in(cke_en_in),
    .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in),
    .req_bank_in(req_bank_in), .req_ap_in(req_ap_in),
    .req_ready_out(req_ready_out), .req_reject_out(req_reject_out));
  dram_bank_tracker i_dram_bank_tracker (
    .clk_in(clk_in), .rst_in(rst_in), .link(lk), .state_out(st_a),
    .taken_out(taken_a), .illegal_out(ill_a));
  dram_bank_tracker i_dram_bank_tracker_2 (
    .clk_in(clk_in), .rst_in(rst_in), .link(lk2), .state_out(st_b),
    .taken_out(taken_b), .illegal_out(ill_b));
  dram_link_checker i_dram_link_checker (
    .clk_in(clk_in), .rst_in(rst_in), .ck(lk.ck), .cke(lk.cke),
    .cmd(lk.cmd), .state_out(st_a), .taken_out(taken_a),
    .illegal_out(ill_a));

  // local clock
  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;

  // free-running clock of the second link, phase unrelated
  initial begin
    lk2.ck = 1'b0;
    #7;
    forever #160 lk2.ck = ~lk2.ck;
  end

  // compare and count
  task automatic check(input logic [3:0] got, input logic [3:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one request, held until the issuer takes or refuses it
  task automatic issue(input cmd_t c, input int b, input logic a,
                       input logic rej);
    int n;
    n = 0;
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_cmd_in   <= c;
    req_bank_in  <= BA_W'(b);
    req_ap_in    <= a;
    do begin
      @(posedge clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 3000);
    req_valid_in <= 1'b0;
    check(4'(req_ready_out), 4'h1, "request taken");
    check(4'(req_reject_out), 4'(rej), "reject flag");
  endtask

  // wait for a bank of the first link to reach a state
  task automatic wst(input int b, input bank_state_t s, input int lim);
    int n;
    n = 0;
    while (st_a[b] !== s && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    check(st_a[b], s, "bank state");
  endtask

  // one command on the second link, pulses collected for one period
  task automatic send2(input cmd_t c, input int b, input logic k,
                       input logic exp_t, input logic exp_i);
    logic tk;
    logic il;
    tk = 1'b0;
    il = 1'b0;
    @(negedge lk2.ck);
    @(posedge clk_in);
    lk2.cmd <= c;
    lk2.ba  <= BA_W'(b);
    lk2.cke <= k;
    @(posedge lk2.ck);
    repeat (8) begin
      @(posedge clk_in);
      tk |= taken_b;
      il |= ill_b;
      if (lk2.ck === 1'b0) lk2.cmd <= CMD_NOP;
    end
    check(4'(tk), 4'(exp_t), "far taken");
    check(4'(il), 4'(exp_i), "far illegal");
  endtask

  task automatic test_reset();
    for (int b = 0; b < BANKS; b++) begin
      check(st_a[b], ST_IDLE, "reset state");
    end
    $display("test reset done");
  endtask

  task automatic test_open_close();
    issue(CMD_ACT, 1, 1'b0, 1'b0);
    issue(CMD_ACT, 2, 1'b0, 1'b0);
    wst(2, ST_ACTIVE, 60);
    check(st_a[1], ST_ACTIVE, "first open bank");
    issue(CMD_RD, 1, 1'b0, 1'b0);
    issue(CMD_WR, 2, 1'b0, 1'b0);
    wst(2, ST_WRITING, 120);
    check(st_a[1], ST_ACTIVE, "read over before write");
    issue(CMD_RD, 1, 1'b0, 1'b0);
    wst(1, ST_READING, 120);
    check(st_a[2], ST_ACTIVE, "write over before read");
    issue(CMD_PRE, 2, 1'b0, 1'b0);
    wst(2, ST_PRECHARGING, 40);
    wst(2, ST_IDLE, 10);
    check(st_a[1], ST_READING, "burst undisturbed");
    wst(1, ST_ACTIVE, 80);
    $display("test open close done");
  endtask

  task automatic test_autopre();
    issue(CMD_RD, 1, 1'b1, 1'b0);
    wst(1, ST_READ_AP, 40);
    issue(CMD_ACT, 4, 1'b0, 1'b0);
    wst(4, ST_ACTIVE, 40);
    check(st_a[1], ST_READ_AP, "still auto precharging");
    wst(1, ST_PRECHARGING, 80);
    wst(1, ST_IDLE, 10);
    issue(CMD_MWR, 4, 1'b1, 1'b0);
    wst(4, ST_WRITE_AP, 40);
    wst(4, ST_IDLE, 90);
    issue(CMD_ACT, 3, 1'b0, 1'b0);
    issue(CMD_WR, 3, 1'b0, 1'b0);
    wst(3, ST_WRITING, 40);
    wst(3, ST_ACTIVE, 80);
    $display("test auto precharge done");
  endtask

  task automatic test_mode_regs();
    issue(CMD_MRR, 3, 1'b0, 1'b0);
    wst(3, ST_MRR_ACTIVE, 40);
    wst(3, ST_ACTIVE, 80);
    issue(CMD_MRR, 6, 1'b0, 1'b0);
    wst(6, ST_MRR_IDLE, 40);
    wst(6, ST_IDLE, 80);
    issue(CMD_PREA, 0, 1'b0, 1'b0);
    wst(3, ST_PRECHARGING, 40);
    wst(3, ST_IDLE, 10);
    issue(CMD_MRW, 0, 1'b0, 1'b0);
    wst(7, ST_MRW_IDLE, 40);
    check(st_a[0], ST_MRW_IDLE, "all banks writing");
    wst(7, ST_IDLE, 90);
    issue(CMD_REF, 0, 1'b0, 1'b0);
    $display("test mode registers done");
  endtask

  task automatic test_refusals();
    issue(CMD_RD, 5, 1'b0, 1'b1);
    issue(CMD_ACT, 5, 1'b0, 1'b0);
    issue(CMD_ACT, 5, 1'b0, 1'b1);
    issue(CMD_MRW, 0, 1'b0, 1'b1);
    issue(CMD_REF, 0, 1'b0, 1'b1);
    issue(CMD_PRE, 5, 1'b0, 1'b0);
    wst(5, ST_IDLE, 60);
    $display("test refusals done");
  endtask

  task automatic test_far_end();
    send2(CMD_ACT, 0, 1'b0, 1'b0, 1'b0);
    send2(CMD_NOP, 0, 1'b1, 1'b0, 1'b0);
    send2(CMD_NOP, 0, 1'b1, 1'b1, 1'b0);
    check(st_b[0], ST_IDLE, "ignored activate");
    send2(CMD_ACT, 0, 1'b1, 1'b1, 1'b0);
    send2(CMD_RD, 7, 1'b1, 1'b0, 1'b1);
    send2(CMD_MRW, 0, 1'b1, 1'b0, 1'b1);
    send2(CMD_NOP, 0, 1'b1, 1'b1, 1'b0);
    check(st_b[0], ST_ACTIVE, "nop keeps open bank");
    check(st_b[7], ST_IDLE, "refused read no change");
    $display("test far end done");
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst_in = 1'b1;
    cke_en_in = 1'b0;
    req_valid_in = 1'b0;
    req_cmd_in = CMD_NOP;
    req_bank_in = '0;
    req_ap_in = 1'b0;
    lk2.cke = 1'b0;
    lk2.cmd = CMD_NOP;
    lk2.ba = '0;
    lk2.ap = 1'b0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    cke_en_in <= 1'b1;
    test_reset();
    test_open_close();
    test_autopre();
    test_mode_regs();
    test_refusals();
    test_far_end();
    final_report();
  end

  // watchdog over the expected run length
  initial begin
    #(40 * 20000);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
